// [design/aonr_top.sv]
// always-on retention store with wishbone registers and direct byte read
`timescale 1ns/1ps
module aonr_top (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic wake_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic upload_cfg_o
);
  // ----------------------------------------------------------------
  // reset and wake synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic [2:0] wk_q;
  wire rst_n = rst_q[1];

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wk_q <= 3'h0;
    end else begin
      wk_q <= {wk_q[1:0], wake_i};
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic [7:0] loc_q;
  logic [7:0] res_q;
  logic [7:0] res_d;
  logic arm_q;
  logic [31:0] cfg_q [aonr_pkg::NW];
  logic [31:0] aon_q [aonr_pkg::NW];
  logic [31:0] rest_v [aonr_pkg::NW];
  logic [31:0] wr_v [aonr_pkg::NW];

  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire [5:0] ix = wb_adr_i[7:2];
  wire wr = req & wb_we_i;
  wire hit_cmd = ix == aonr_pkg::IX_CMD;
  wire hit_res = ix == aonr_pkg::IX_RES;
  wire hit_loc = ix == aonr_pkg::IX_LOC;
  wire hit_spr = ix == aonr_pkg::IX_SPR;
  wire [5:0] cw = ix - aonr_pkg::IX_CFG;
  wire hit_cfg = (ix >= aonr_pkg::IX_CFG) && (cw < 6'(aonr_pkg::NW));
  wire wr_cmd = wr & hit_cmd & wb_sel_i[0];
  wire wr_res = wr & hit_res & wb_sel_i[0];
  wire wr_loc = wr & hit_loc & wb_sel_i[0];

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  // wake is blocked while direct access is enabled
  wire wake_go = wk_q[1] & ~wk_q[2] & ~cmd_q[aonr_pkg::B_DEN];
  wire restore_go = cmd_q[aonr_pkg::B_RST] | wake_go;
  wire save_go = cmd_q[aonr_pkg::B_SAVE];
  wire arm = cmd_q[aonr_pkg::B_DRD] & cmd_q[aonr_pkg::B_DEN];
  wire rd_go = arm & ~arm_q;

  always_comb begin
    cmd_d = cmd_q;
    cmd_d[aonr_pkg::B_RST] = 1'b0;
    cmd_d[aonr_pkg::B_SAVE] = 1'b0;
    if (wr_cmd) begin
      cmd_d = wb_dat_i[7:0] & aonr_pkg::CMD_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // direct read of the retention store
  // ----------------------------------------------------------------
  wire [5:0] lw = loc_q[7:2];
  wire [31:0] lword = (lw < 6'(aonr_pkg::NW)) ? aon_q[lw[3:0]] : 32'h00000000;
  wire [31:0] lshift = lword >> {loc_q[1:0], 3'h0};
  wire [7:0] rd_byte = lshift[7:0];

  // a completing read wins over a host write in the same cycle
  always_comb begin
    res_d = res_q;
    if (wr_res) begin
      res_d = wb_dat_i[7:0];
    end
    if (rd_go) begin
      res_d = rd_byte;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= aonr_pkg::CMD_RST;
      loc_q <= aonr_pkg::LOC_RST;
      res_q <= aonr_pkg::RES_RST;
      arm_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      loc_q <= wr_loc ? wb_dat_i[7:0] : loc_q;
      res_q <= res_d;
      arm_q <= arm;
    end
  end

  // ----------------------------------------------------------------
  // configuration words and their retained copies
  // ----------------------------------------------------------------
  for (genvar w = 0; w < aonr_pkg::NW; w++) begin : g_word
    wire [31:0] kept = (aon_q[w] & aonr_pkg::KEEP[w]) |
                       (aonr_pkg::CFG_RST[w] & ~aonr_pkg::KEEP[w]);
    wire wsel = wr & hit_cfg & (cw == 6'(w));
    if (w == aonr_pkg::W_TXANTD) begin : g_antd
      // transmit delay comes back holding the low half of the retained receive delay
      assign rest_v[w] = {aonr_pkg::CFG_RST[w][31:aonr_pkg::ANTD_W],
                          aon_q[aonr_pkg::W_RXANTD][aonr_pkg::ANTD_W-1:0]};
    end else begin : g_keep
      assign rest_v[w] = kept;
    end
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wr_v[w][8*b +: 8] = (wsel & wb_sel_i[b]) ? wb_dat_i[8*b +: 8] :
                                 cfg_q[w][8*b +: 8];
    end
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        cfg_q[w] <= aonr_pkg::CFG_RST[w];
        aon_q[w] <= aonr_pkg::CFG_RST[w];
      end else begin
        cfg_q[w] <= restore_go ? rest_v[w] : wr_v[w];
        aon_q[w] <= save_go ? (cfg_q[w] & aonr_pkg::KEEP[w]) : aon_q[w];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and answer
  // ----------------------------------------------------------------
  wire [31:0] rdata = hit_cmd ? {24'h000000, cmd_q} :
                      hit_res ? {24'h000000, res_q} :
                      hit_loc ? {24'h000000, loc_q} :
                      hit_cfg ? cfg_q[cw[3:0]] :
                      32'h00000000;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      upload_cfg_o <= 1'b0;
    end else begin
      ack_q <= req;
      dat_q <= req ? rdata : dat_q;
      upload_cfg_o <= cmd_d[aonr_pkg::B_UPL];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sys_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_SYSCFG] == $past(aon_q[aonr_pkg::W_SYSCFG]))
    else $error("system word not restored");
  txf_low_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_TXFCTL] == $past(aon_q[aonr_pkg::W_TXFCTL]))
    else $error("frame control word not kept");
  sniff_bit_a: assert property (restore_go |=>
    !cfg_q[aonr_pkg::W_SNIFF][0])
    else $error("sniff bit zero not cleared");
  sfd_len_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_SFD][31:8] == aonr_pkg::CFG_RST[aonr_pkg::W_SFD][31:8])
    else $error("delimiter upper bits kept");
  antd_over_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_TXANTD][15:0] == $past(aon_q[aonr_pkg::W_RXANTD][15:0]))
    else $error("transmit delay not overwritten");
  pwr0_keep_a: assert property (restore_go |=>
    (cfg_q[aonr_pkg::W_PWR0] & 32'hff7f67bf) == 32'h00000000)
    else $error("power zero lost bits not reverted");
  pwr1_div_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_PWR1][31:26] == 6'h00)
    else $error("slow clock divider not reverted");
  led_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_LEDC][7:0] == 8'h00)
    else $error("blink time not reverted");
  res_read_a: assert property (req && hit_res && !wb_we_i |=>
    wb_ack_o && wb_dat_o == {24'h000000, $past(res_q)})
    else $error("read result byte wrong");
  loc_write_a: assert property (wr_loc |=>
    loc_q == $past(wb_dat_i[7:0]))
    else $error("location byte not written");
  dread_fill_a: assert property ($rose(arm) |=>
    res_q == $past(rd_byte))
    else $error("direct read result missing");
  dread_gate_a: assert property (!cmd_q[aonr_pkg::B_DEN] && !wr_res |=>
    $stable(res_q))
    else $error("direct read without enable");
  spare_zero_a: assert property (req && hit_spr |=>
    wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("spare byte not zero");
  save_clr_a: assert property (save_go && !wr_cmd |=>
    !cmd_q[aonr_pkg::B_SAVE] &&
    aon_q[aonr_pkg::W_SYSCFG] == $past(cfg_q[aonr_pkg::W_SYSCFG]))
    else $error("save not done or not cleared");

  // ----------------------------------------------------------------
  // bus handshake and byte register checks
  // ----------------------------------------------------------------
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("request not answered");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  upl_copy_a: assert property (wr_cmd |=> upload_cfg_o == $past(wb_dat_i[2]))
    else $error("upload output wrong");
  rst_clr_a: assert property (restore_go && !wr_cmd |=> !cmd_q[aonr_pkg::B_RST])
    else $error("restore bit not cleared");
  cmd_mask_a: assert property (wr_cmd |=> cmd_q[6:4] == 3'h0)
    else $error("unused command bits stored");
  dread_cmd_a: assert property (!cmd_q[aonr_pkg::B_DRD] && !wr_res |=> $stable(res_q))
    else $error("direct read without command");
  loc_hold_a: assert property (!wr_loc |=> $stable(loc_q))
    else $error("location byte changed");
  res_write_a: assert property (wr_res && !rd_go |=>
    res_q == $past(wb_dat_i[7:0]))
    else $error("read result byte not written");
  spare_write_a: assert property (wr && hit_spr |=>
    $stable(loc_q) && $stable(cmd_q[7:2]))
    else $error("spare write changed a register");
  // ----------------------------------------------------------------
  // configuration word checks
  // ----------------------------------------------------------------
  cfg_write_a: assert property (wr && hit_cfg && cw == 6'(aonr_pkg::W_SYSCFG) &&
    wb_sel_i == 4'hf && !restore_go |=> cfg_q[aonr_pkg::W_SYSCFG] == $past(wb_dat_i))
    else $error("config word not written");
  cfg_hold_a: assert property (!wr && !restore_go |=>
    $stable(cfg_q[aonr_pkg::W_CHAN]))
    else $error("config word changed");
  aon_hold_a: assert property (!save_go |=> $stable(aon_q[aonr_pkg::W_GPIO]))
    else $error("retained word changed");
  wake_block_a: assert property (wk_q[1] && !wk_q[2] && cmd_q[aonr_pkg::B_DEN] &&
    !cmd_q[aonr_pkg::B_RST] && !wr |=> $stable(cfg_q[aonr_pkg::W_XTAL]))
    else $error("restore ran while direct access enabled");
  xtal_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_XTAL] == $past(aon_q[aonr_pkg::W_XTAL]))
    else $error("crystal trim not restored");
  gpio_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_GPIO] == $past(aon_q[aonr_pkg::W_GPIO]))
    else $error("gpio mode not restored");
  txpwr_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_TXPWR] == $past(aon_q[aonr_pkg::W_TXPWR]))
    else $error("transmit power not restored");
  evmask_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_EVMASK] == $past(aon_q[aonr_pkg::W_EVMASK]))
    else $error("event mask not restored");
  sniff_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_SNIFF][31:1] == $past(aon_q[aonr_pkg::W_SNIFF][31:1]))
    else $error("sniff upper bits not restored");
  sfd_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_SFD][7:0] == $past(aon_q[aonr_pkg::W_SFD][7:0]))
    else $error("delimiter length not restored");
  pwr1_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_PWR1][25:0] == $past(aon_q[aonr_pkg::W_PWR1][25:0]))
    else $error("power one bits not restored");
  blink_keep_a: assert property (restore_go |=>
    cfg_q[aonr_pkg::W_LEDC][8] == $past(aon_q[aonr_pkg::W_LEDC][8]))
    else $error("blink enable not restored");
  pwr0_bits_a: assert property (restore_go |=>
    (cfg_q[aonr_pkg::W_PWR0] & 32'h00809840) == ($past(aon_q[aonr_pkg::W_PWR0]) & 32'h00809840))
    else $error("power zero kept bits lost");
  save_mask_a: assert property (save_go |=> !aon_q[aonr_pkg::W_SNIFF][0])
    else $error("sniff bit zero retained");

  wake_c: cover property (wk_q[1] && !wk_q[2] && wake_go);
  dread_c: cover property (rd_go ##[1:4] req && hit_res && !wb_we_i);
  save_c: cover property (save_go ##[1:100] restore_go);
  restore_c: cover property (restore_go && !wake_go);
  block_c: cover property (wk_q[1] && !wk_q[2] && cmd_q[aonr_pkg::B_DEN]);
endmodule

// [dv/aon_retention_direct_read_bench.sv]
// self-checking bench for the retention store
`timescale 1ns/1ps
module aon_retention_direct_read_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wake = 1'b0;
  logic cyc, stb, we, ack, upl;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int err_total = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  aonr_top i_dut (.sys_clk_i(clk), .rstn_i(rstn), .wake_i(wake), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .upload_cfg_o(upl));
  aonr_host i_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [31:0] d);
    i_host.xfer(1'b1, ix, d, q);
  endtask
  task automatic rd(input logic [5:0] ix);
    i_host.xfer(1'b0, ix, 32'h00000000, q);
  endtask
  task automatic fill(input logic [31:0] d);
    for (int w = 0; w < aonr_pkg::NW; w++) wr(6'(aonr_pkg::IX_CFG + w), d);
  endtask
  task automatic t_cfg;
    for (int w = 0; w < aonr_pkg::NW; w++) begin
      rd(6'(aonr_pkg::IX_CFG + w));
      // tx delay comes back as the low half of the retained rx delay
      check(q, (w == aonr_pkg::W_TXANTD) ? 32'h0000ffff : aonr_pkg::KEEP[w]);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(aonr_pkg::IX_RES);
    check(q, 32'h00000000);
    rd(6'h3f);
    check(q, 32'h00000000);
    wr(aonr_pkg::IX_LOC, 32'hffffffa5);
    rd(aonr_pkg::IX_LOC);
    check(q, 32'h000000a5);
    wr(aonr_pkg::IX_SPR, 32'h000000ff);
    rd(aonr_pkg::IX_SPR);
    check(q, 32'h00000000);
    wr(aonr_pkg::IX_CMD, 32'h00000074);
    check({31'h0, upl}, 32'h00000001);
    rd(aonr_pkg::IX_CMD);
    check(q, 32'h00000004);
    wr(aonr_pkg::IX_CMD, 32'h00000000);
  endtask
  task automatic t_keep;
    fill(32'hffffffff);
    wr(aonr_pkg::IX_CMD, 32'h00000002);
    rd(aonr_pkg::IX_CMD);
    check(q, 32'h00000000);
    fill(32'h00000000);
    wr(aonr_pkg::IX_CMD, 32'h00000001);
    rd(aonr_pkg::IX_CMD);
    check(q, 32'h00000000);
    t_cfg();
  endtask
  task automatic t_wake;
    // with direct access enabled a wake must not restore
    wr(aonr_pkg::IX_CMD, 32'h00000080);
    wr(6'(aonr_pkg::IX_CFG + aonr_pkg::W_XTAL), 32'h5a5a5a5a);
    wake <= 1'b1;
    repeat (8) @(posedge clk);
    wake <= 1'b0;
    repeat (4) @(posedge clk);
    rd(6'(aonr_pkg::IX_CFG + aonr_pkg::W_XTAL));
    check(q, 32'h5a5a5a5a);
    wr(aonr_pkg::IX_CMD, 32'h00000000);
    fill(32'h00000000);
    wake <= 1'b1;
    repeat (8) @(posedge clk);
    wake <= 1'b0;
    t_cfg();
    wr(6'(aonr_pkg::IX_CFG + aonr_pkg::W_TXANTD), 32'h00001234);
    rd(6'(aonr_pkg::IX_CFG + aonr_pkg::W_TXANTD));
    check(q, 32'h00001234);
  endtask
  task automatic t_direct;
    logic [31:0] exp;
    wr(aonr_pkg::IX_RES, 32'h00000000);
    // location 0 holds a nonzero byte, so a wrongly taken read shows
    wr(aonr_pkg::IX_LOC, 32'h00000000);
    wr(aonr_pkg::IX_CMD, 32'h00000008);
    rd(aonr_pkg::IX_RES);
    check(q, 32'h00000000);
    wr(aonr_pkg::IX_CMD, 32'h00000000);
    for (int i = 0; i < 16; i++) begin
      exp = 32'h00000000;
      if (i < aonr_pkg::NW) exp = (aonr_pkg::KEEP[i] >> (8 * (i % 4))) & 32'h000000ff;
      i_host.dread(8'(i * 4 + i % 4), q);
      check(q, exp);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_keep();
    t_wake();
    t_direct();
    wrap_up();
  end
  initial begin
    #40000;
    err_total++;
    wrap_up();
  end
endmodule

// [dv/aonr_host.sv]
// host model: classic wishbone master driving the retention store registers
`timescale 1ns/1ps
module aonr_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [5:0] ix, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {ix, 2'b00};
    sel_o <= 4'hf;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released lines stop showing the last request
    adr_o <= ~adr_o;
    dat_o <= ~dat_o;
  endtask
  // location first, then enable, then command; clear both after collecting
  task automatic dread(input logic [7:0] loc, output logic [31:0] q);
    logic [31:0] s;
    xfer(1'b1, aonr_pkg::IX_LOC, {24'h000000, loc}, s);
    xfer(1'b1, aonr_pkg::IX_CMD, 32'h00000080, s);
    xfer(1'b1, aonr_pkg::IX_CMD, 32'h00000088, s);
    xfer(1'b0, aonr_pkg::IX_RES, 32'h00000000, q);
    xfer(1'b1, aonr_pkg::IX_CMD, 32'h00000000, s);
  endtask
endmodule

// [include/aonr_pkg.sv]
// constants for the always-on retention store and its direct read path
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package aonr_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] IX_CMD = 6'h02;
  localparam logic [5:0] IX_RES = 6'h03;
  localparam logic [5:0] IX_LOC = 6'h04;
  localparam logic [5:0] IX_SPR = 6'h05;
  localparam logic [5:0] IX_CFG = 6'h10;
  // retention command byte fields
  localparam int B_RST = 0;
  localparam int B_SAVE = 1;
  localparam int B_UPL = 2;
  localparam int B_DRD = 3;
  localparam int B_DEN = 7;
  localparam logic [7:0] CMD_WMASK = 8'h8f;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] LOC_RST = 8'h00;
  localparam logic [7:0] RES_RST = 8'h00;
  // configuration word slots
  localparam int NW = 14;
  localparam int W_SYSCFG = 0;
  localparam int W_EVMASK = 1;
  localparam int W_TXFCTL = 2;
  localparam int W_SNIFF = 3;
  localparam int W_TXPWR = 4;
  localparam int W_CHAN = 5;
  localparam int W_SFD = 6;
  localparam int W_GPIO = 7;
  localparam int W_XTAL = 8;
  localparam int W_RXANTD = 9;
  localparam int W_TXANTD = 10;
  localparam int W_PWR0 = 11;
  localparam int W_PWR1 = 12;
  localparam int W_LEDC = 13;
  localparam int ANTD_W = 16;
  localparam logic [31:0] KEEP [NW] = '{
    32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hfffffffe,
    32'hffffffff, 32'hffffffff, 32'h000000ff, 32'hffffffff,
    32'hffffffff, 32'hffffffff, 32'h00000000, 32'h00809840,
    32'h03ffffff, 32'h00000100};
  localparam logic [31:0] CFG_RST [NW] = '{default: 32'h00000000};
endpackage
